// [rtl/dhp_dev.sv]
// controller end: muxed bus slave, request/clear-to-send, transmit data and clock pins
// Contract
// - set request bit drives request-to-send low
// - release request only after transmitter idle
// - bus mode: low during frame, delayed
// - transmit only while clear-to-send low
// - shared bus wired to collision input
// - transmit data push-pull or open-drain
// - hard reset high forces reset state
// - reset held at least 1.8 us
// - power-up in reset, power-down after
// - open-drain interrupt while interrupt pending
// - strobe high marks address on bus
// - respond only while chip select low
// - write strobe marks write cycle
// - read strobe marks read cycle
// - eight-bit bus carries data both ways
// - transmit clock pin accepts clock or strobe
// - mode 5: channel A pin is frame sync
// - output: clock, or B time-slot control
// - receive clock pin source is programmable
`timescale 1ns/1ps
module dhp_dev
	import dhp_pkg::*;
(
	input  wire logic       MCLK,
	dhp_if.dev              PINS,
	input  wire logic [1:0] TX_BIT,
	input  wire logic [1:0] TX_BUSY,
	input  wire logic [1:0] COLL_BIT,
	input  wire logic [1:0] TIME_SLOT,
	input  wire logic [1:0] IRQ_PEND,
	input  wire logic [1:0] CHAN_CLEAR_OR_COLLISION_IN,
	input  wire logic [1:0] TXCLK_IN,
	input  wire logic [1:0] RECEIVE_CLOCK_PIN,
	input  wire logic [1:0] TX_CLK_GEN,
	input  wire logic [1:0] RX_CLK_GEN,
	input  wire logic [1:0] BRG_CLK,
	input  wire logic [1:0] DPLL_CLK,
	output logic [1:0]      RTS_N,
	output logic [1:0]      TXD_O,
	output logic [1:0]      TXD_OE_N,
	output logic [1:0]      TXCLK_O,
	output logic [1:0]      TXCLK_OE_N,
	output logic [1:0]      TX_ENABLE,
	output logic [1:0]      TX_CLK_SEL,
	output logic [1:0]      RX_STROBE,
	output logic            FRAME_SYNC,
	output logic [1:0]      RX_CLK_SEL,
	output logic [1:0]      POWER_DOWN,
	output logic [1:0]      XTAL_EN
);
	// ==========================================
	// pin synchronisers
	logic [15:0] s1_reg, s2_reg, s1_next;
	logic [7:0]  ad1_reg, ad2_reg, ad3_reg;
	always_comb
	begin
		s1_next = {PINS.hard_reset_in, PINS.ale, PINS.cs_n, PINS.wr_n, PINS.rd_n,
			CHAN_CLEAR_OR_COLLISION_IN, TXCLK_IN, RECEIVE_CLOCK_PIN, IRQ_PEND, 3'h0};
	end
	always_ff @(posedge MCLK)
	begin
		s1_reg  <= s1_next;
		s2_reg  <= s1_reg;
		ad1_reg <= PINS.ad;
		ad2_reg <= ad1_reg;
	end
	logic       rst_s, ale_s, cs_n_s, wr_n_s, rd_n_s;
	logic [1:0] cts_n_s, txclk_s, rxck_s, irq_s;
	assign {rst_s, ale_s, cs_n_s, wr_n_s, rd_n_s, cts_n_s, txclk_s, rxck_s, irq_s} = s2_reg[15:3];

	// ==========================================
	// register state
	logic [7:0] addr_reg, addr_next;
	logic       ale_d_reg;
	logic       wr_d_reg, wr_d_next;
	logic [7:0] mode_reg [2], mode_next [2];
	logic [2:0] clkm_reg [2], clkm_next [2];
	logic [7:0] rdata_reg, rdata_next;
	logic       drive_reg, drive_next;
	logic [1:0] rts_n_reg, rts_n_next;
	logic [1:0] send_d_reg;
	logic [1:0] pd_reg, pd_next;

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ADDR_MODE_A: v = mode_reg[0];
			ADDR_MODE_B: v = mode_reg[1];
			ADDR_CLKM_A: v = {5'h00, clkm_reg[0]};
			ADDR_CLKM_B: v = {5'h00, clkm_reg[1]};
			ADDR_STATUS: v = {2'h0, TX_BUSY, cts_n_s, rts_n_reg};
			ADDR_IRQ:    v = {6'h00, irq_s};
			default:     v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb
	begin
		addr_next  = addr_reg;
		mode_next  = mode_reg;
		clkm_next  = clkm_reg;
		rdata_next = rdata_reg;
		wr_d_next  = !wr_n_s && !cs_n_s;
		drive_next = !rd_n_s && !cs_n_s && !ale_s;
		pd_next    = pd_reg;
		// ad3 lines up with the strobe sample that ale_d_reg holds
		if (ale_d_reg && !ale_s)
			addr_next = ad3_reg;
		if (!rd_n_s && !cs_n_s)
			rdata_next = rd_mux(addr_reg);
		if (wr_d_reg && !(!wr_n_s && !cs_n_s))
		begin
			unique case (addr_reg)
				ADDR_MODE_A: mode_next[0] = ad2_reg;
				ADDR_MODE_B: mode_next[1] = ad2_reg;
				ADDR_CLKM_A: clkm_next[0] = ad2_reg[2:0];
				ADDR_CLKM_B: clkm_next[1] = ad2_reg[2:0];
				default: ;
			endcase
		end
		for (int c = 0; c < 2; c++)
		begin
			if (mode_reg[c][MODE_BUS_BIT])
				rts_n_next[c] = !(send_d_reg[c] && !COLL_BIT[c]);
			else if (mode_reg[c][MODE_RTS_BIT])
				rts_n_next[c] = 1'b0;
			else if (TX_BUSY[c])
				rts_n_next[c] = rts_n_reg[c];
			else
				rts_n_next[c] = 1'b1;
		end
		pd_next = 2'b11;
		if (rst_s)
		begin
			addr_next  = 8'h00;
			mode_next  = '{MODE_RST, MODE_RST};
			clkm_next  = '{CLKM_RST, CLKM_RST};
			rdata_next = 8'h00;
			drive_next = 1'b0;
			rts_n_next = 2'b11;
			pd_next    = 2'b00;
		end
	end

	always_ff @(posedge MCLK)
	begin
		ale_d_reg  <= ale_s;
		ad3_reg    <= ad2_reg;
		send_d_reg <= TX_BUSY & TX_ENABLE;
		wr_d_reg   <= wr_d_next;
	end
	// reset values come in through rst_s in the next-state logic
	always_ff @(posedge MCLK)
	begin
		addr_reg  <= addr_next;
		mode_reg  <= mode_next;
		clkm_reg  <= clkm_next;
		rdata_reg <= rdata_next;
		drive_reg <= drive_next;
		rts_n_reg <= rts_n_next;
		pd_reg    <= pd_next;
	end

	// ==========================================
	// pins
	assign PINS.ad_dev_o    = rdata_reg;
	assign PINS.ad_dev_oe_n = !drive_reg;
	assign PINS.int_o       = 1'b0;
	assign PINS.int_oe_n    = !(|irq_s);
	assign RTS_N            = rts_n_reg;
	assign POWER_DOWN       = pd_reg;
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			logic fs;
			fs            = (clkm_reg[c] == CLKM_FSYNC);
			TX_ENABLE[c]  = !cts_n_s[c];
			TXD_O[c]      = mode_reg[c][MODE_OD_BIT] ? 1'b0 : TX_BIT[c];
			TXD_OE_N[c]   = mode_reg[c][MODE_OD_BIT] ? TX_BIT[c] : 1'b0;
			TXCLK_OE_N[c] = !mode_reg[c][MODE_TXC_OUT];
			TXCLK_O[c]    = (c == 1 && fs) ? TIME_SLOT[1] : TX_CLK_GEN[c];
			TX_CLK_SEL[c] = mode_reg[c][MODE_TXC_OUT] ? TX_CLK_GEN[c] : txclk_s[c];
			unique case (clkm_reg[c][1:0])
				2'h0: RX_CLK_SEL[c] = rxck_s[c];
				2'h1: RX_CLK_SEL[c] = RX_CLK_GEN[c];
				2'h2: RX_CLK_SEL[c] = BRG_CLK[c];
				default: RX_CLK_SEL[c] = DPLL_CLK[c];
			endcase
			XTAL_EN[c]    = clkm_reg[c] == 3'h7;
		end
		RX_STROBE  = {txclk_s[1], (clkm_reg[0] != CLKM_FSYNC) && txclk_s[0]};
		FRAME_SYNC = (clkm_reg[0] == CLKM_FSYNC) && txclk_s[0];
	end
endmodule

// [rtl/dhp_host.sv]
// processor end: AHB-Lite slave bridge that runs muxed-bus cycles and the hard reset
`timescale 1ns/1ps
module dhp_host
	import dhp_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	dhp_if.host              PINS,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP
);
	// ==========================================
	// synchronised device-driven pins
	logic [8:0] p1_reg, p2_reg;
	always_ff @(posedge MCLK)
	begin
		p1_reg <= {PINS.int_n, PINS.ad};
		p2_reg <= p1_reg;
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_ALE = 3'b001, ST_GAP = 3'b010,
		ST_STB = 3'b011, ST_END = 3'b100, ST_RST = 3'b101
	} dhp_st_t;
	dhp_st_t    st_reg, st_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] a_reg, a_next, wd_reg, wd_next, rd_reg, rd_next;
	logic       rw_reg, rw_next, busy;
	logic       dph_reg, dph_next, dwr_reg, dwr_next;
	logic [7:0] dad_reg, dad_next;
	logic [31:0] hr_reg, hr_next;

	assign busy      = st_reg != ST_IDLE;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = hr_reg;

	always_comb
	begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		a_next   = a_reg;
		wd_next  = wd_reg;
		rd_next  = rd_reg;
		rw_next  = rw_reg;
		dph_next = HSEL && HREADY && HTRANS[1];
		dwr_next = HWRITE;
		dad_next = HADDR[7:0];
		hr_next  = hr_reg;
		if (dph_reg && dwr_reg)
		begin
			if (dad_reg == HREG_ADDR)
				a_next = HWDATA[7:0];
			if (dad_reg == HREG_WDATA)
				wd_next = HWDATA[7:0];
			if (dad_reg == HREG_CMD && !busy)
			begin
				rw_next  = HWDATA[0];
				st_next  = ST_ALE;
				cnt_next = 8'(STROBE_CYC);
			end
			if (dad_reg == HREG_RESET && !busy)
			begin
				st_next  = ST_RST;
				cnt_next = 8'(RESET_CYC);
			end
		end
		if (dph_next && !HWRITE)
		begin
			unique case (HADDR[7:0])
				HREG_ADDR:   hr_next = {24'h0, a_reg};
				HREG_WDATA:  hr_next = {24'h0, wd_reg};
				HREG_RDATA:  hr_next = {24'h0, rd_reg};
				HREG_STATUS: hr_next = {30'h0, !p2_reg[8], busy};
				default:     hr_next = 32'h0;
			endcase
		end
		if (busy && !(dph_reg && dwr_reg && !busy))
		begin
			// read data needs two pin stages plus the controller's answer time
			if (st_reg == ST_END && cnt_reg == 8'(STROBE_CYC) && !rw_reg)
				rd_next = p2_reg[7:0];
			if (cnt_reg != 8'h00)
				cnt_next = cnt_reg - 8'h01;
			else
			begin
				cnt_next = 8'(STROBE_CYC);
				unique case (st_reg)
					ST_ALE:  st_next = ST_GAP;
					ST_GAP:  st_next = ST_STB;
					ST_STB:  st_next = ST_END;
					ST_END:  st_next = ST_IDLE;
					ST_RST:  st_next = ST_IDLE;
					default: st_next = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			st_reg  <= ST_IDLE;
			cnt_reg <= 8'h00;
			a_reg   <= 8'h00;
			wd_reg  <= 8'h00;
			rd_reg  <= 8'h00;
			rw_reg  <= 1'b0;
			dph_reg <= 1'b0;
			dwr_reg <= 1'b0;
			dad_reg <= 8'h00;
			hr_reg  <= 32'h0;
		end
		else
		begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			a_reg   <= a_next;
			wd_reg  <= wd_next;
			rd_reg  <= rd_next;
			rw_reg  <= rw_next;
			dph_reg <= dph_next;
			dwr_reg <= dwr_next;
			dad_reg <= dad_next;
			hr_reg  <= hr_next;
		end
	end

	// ==========================================
	// muxed bus pins
	assign PINS.hard_reset_in = st_reg == ST_RST;
	assign PINS.ale           = st_reg == ST_ALE;
	assign PINS.cs_n          = !(st_reg == ST_GAP || st_reg == ST_STB);
	assign PINS.wr_n          = !(st_reg == ST_STB && rw_reg);
	assign PINS.rd_n          = !(st_reg == ST_STB && !rw_reg);
	assign PINS.ad_host_o     = st_reg == ST_ALE ? a_reg : wd_reg;
	// write data stays on through the end phase so the late-synchronised commit sees it
	assign PINS.ad_host_oe_n  = !(st_reg == ST_ALE || (rw_reg && (st_reg == ST_GAP
		|| st_reg == ST_STB || st_reg == ST_END)));
endmodule

// [rtl/dhp_if.sv]
// interface: pins between the processor side and the controller
`timescale 1ns/1ps
interface dhp_if;
	logic       hard_reset_in;
	logic       ale;
	logic       cs_n;
	logic       wr_n;
	logic       rd_n;
	logic [7:0] ad_host_o;
	logic       ad_host_oe_n;
	logic [7:0] ad_dev_o;
	logic       ad_dev_oe_n;
	logic       int_o;
	logic       int_oe_n;
	logic [7:0] ad;
	logic       int_n;
	assign ad    = !ad_host_oe_n ? ad_host_o : (!ad_dev_oe_n ? ad_dev_o : 8'hFF);
	assign int_n = !int_oe_n ? int_o : 1'b1;
	modport dev  (input hard_reset_in, ale, cs_n, wr_n, rd_n, ad, output ad_dev_o,
		ad_dev_oe_n, int_o, int_oe_n);
	modport host (output hard_reset_in, ale, cs_n, wr_n, rd_n, ad_host_o, ad_host_oe_n,
		input ad, int_n);
endinterface

// [rtl/dhp_pkg.sv]
// package: constants shared by the two ends of the frame-link controller pin interface
package dhp_pkg;
	// ==========================================
	// internal selector map (muxed bus address)
	localparam logic [7:0] ADDR_MODE_A   = 8'h00;
	localparam logic [7:0] ADDR_MODE_B   = 8'h01;
	localparam logic [7:0] ADDR_CLKM_A   = 8'h02;
	localparam logic [7:0] ADDR_CLKM_B   = 8'h03;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ      = 8'h05;
	// mode register fields
	localparam int MODE_RTS_BIT = 0;
	localparam int MODE_BUS_BIT = 1;
	localparam int MODE_OD_BIT  = 2;
	localparam int MODE_TXC_OUT = 3;
	localparam int MODE_SEND    = 4;
	localparam int MODE_PEND    = 5;
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [2:0] CLKM_RST     = 3'h0;
	localparam logic [2:0] CLKM_FSYNC   = 3'h5;
	// ==========================================
	// host bridge registers (AHB-Lite, byte addresses)
	localparam logic [7:0] HREG_CMD     = 8'h00;
	localparam logic [7:0] HREG_ADDR    = 8'h04;
	localparam logic [7:0] HREG_WDATA   = 8'h08;
	localparam logic [7:0] HREG_RDATA   = 8'h0C;
	localparam logic [7:0] HREG_STATUS  = 8'h10;
	localparam logic [7:0] HREG_RESET   = 8'h14;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int RESET_MIN_PS   = 1800000;
	localparam int RESET_CYC      = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STROBE_CYC     = 4;
endpackage

// [sim/dhp_props.sv]
// checker: muxed bus and hard reset rules on the pins between both ends
`timescale 1ns/1ps
module dhp_props
	import dhp_pkg::*;
(
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic hard_reset_in,
	input wire logic ale,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic ad_host_oe_n,
	input wire logic ad_dev_oe_n,
	input wire logic int_o,
	input wire logic int_oe_n
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	logic [7:0] rst_len_reg;
	logic [7:0] rst_len_next;
	// ==========================================
	// length of the current hard reset pulse
	always_comb
	begin
		rst_len_next = hard_reset_in ? rst_len_reg + ((rst_len_reg == 8'hFF) ? 8'h00 : 8'h01) : 8'h00;
	end
	always_ff @(posedge MCLK)
	begin
		rst_len_reg <= rst_len_next;
	end
	// ==========================================
	// sequences and properties
	sequence s_wr_start;
		$fell(wr_n);
	endsequence
	sequence s_rst_held;
		hard_reset_in [*4];
	endsequence
	AST_NO_CONTENTION: assert property (!(!ad_host_oe_n && !ad_dev_oe_n))
		else $error("both ends drive the muxed bus");
	AST_HOST_QUIET_READ: assert property (!rd_n |-> ad_host_oe_n)
		else $error("processor drives the bus during a read");
	AST_WR_NEEDS_CS: assert property (!wr_n |-> !cs_n)
		else $error("write strobe without chip select");
	AST_RD_NEEDS_CS: assert property (!rd_n |-> !cs_n)
		else $error("read strobe without chip select");
	AST_ALE_ALONE: assert property (ale |-> rd_n && wr_n && !ad_host_oe_n)
		else $error("address phase overlaps a strobe or bus undriven");
	AST_STROBE_EXCL: assert property (!(!rd_n && !wr_n))
		else $error("read and write strobes together");
	AST_WR_LEN: assert property (s_wr_start |-> (!wr_n) [*4])
		else $error("write strobe too short");
	AST_RST_LEN: assert property ($fell(hard_reset_in) |-> rst_len_reg >= RESET_CYC)
		else $error("hard reset pulse too short");
	AST_RST_QUIET: assert property (s_rst_held |-> ad_dev_oe_n)
		else $error("controller drives the bus in reset");
	AST_DEV_NOT_ALE: assert property (!ad_dev_oe_n |-> !ale)
		else $error("controller drives during the address phase");
	AST_INT_OPEN_DRAIN: assert property (!int_oe_n |-> !int_o)
		else $error("interrupt line driven high");
endmodule

// [sim/dual_hdlc_controller_pin_interface_bench.sv]
// testbench: AHB-Lite orders through the processor end, controller pins observed
`timescale 1ns/1ps
module dual_hdlc_controller_pin_interface_bench
	import dhp_pkg::*;
;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  tx_bit = 2'h0, tx_busy = 2'h0, time_slot = 2'h0, irq_pend = 2'h0;
	logic [1:0]  cts = 2'h3, txclk_in = 2'h0, tx_clk_gen = 2'h0, coll_bit = 2'h0;
	logic [1:0]  rts_n, txd_o, txd_oe_n, txclk_o, txclk_oe_n, tx_en, xtal_en, power_down;
	logic        frame_sync;
	logic [1:0]  rx_strobe;
	logic [31:0] r;
	int          n_fail = 0;
	int          cmp_count = 0;
	dhp_if bus();
	dhp_host i_dhp_host(.MCLK(mclk), .SYS_RST(sys_rst), .PINS(bus.host), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));
	dhp_dev i_dhp_dev(.MCLK(mclk), .PINS(bus.dev), .TX_BIT(tx_bit), .TX_BUSY(tx_busy),
		.COLL_BIT(coll_bit), .TIME_SLOT(time_slot), .IRQ_PEND(irq_pend),
		.CHAN_CLEAR_OR_COLLISION_IN(cts), .TXCLK_IN(txclk_in), .RECEIVE_CLOCK_PIN(2'h0),
		.TX_CLK_GEN(tx_clk_gen), .RX_CLK_GEN(2'h0), .BRG_CLK(2'h0), .DPLL_CLK(2'h0),
		.RTS_N(rts_n), .TXD_O(txd_o), .TXD_OE_N(txd_oe_n), .TXCLK_O(txclk_o),
		.TXCLK_OE_N(txclk_oe_n), .TX_ENABLE(tx_en), .TX_CLK_SEL(), .RX_STROBE(rx_strobe),
		.FRAME_SYNC(frame_sync), .RX_CLK_SEL(), .POWER_DOWN(power_down), .XTAL_EN(xtal_en));
	dhp_props i_dhp_props(.MCLK(mclk), .SYS_RST(sys_rst), .hard_reset_in(bus.hard_reset_in),
		.ale(bus.ale), .cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
		.ad_host_oe_n(bus.ad_host_oe_n), .ad_dev_oe_n(bus.ad_dev_oe_n), .int_o(bus.int_o),
		.int_oe_n(bus.int_oe_n));
	// ==========================================
	// shared tasks
	task automatic conclude();
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wait_idle();
		r = 32'h1;
		for (int i = 0; i < 400 && r[0] !== 1'b0; i++)
			ahb(1'b0, HREG_STATUS, 32'h0);
	endtask
	task automatic dev_acc(input logic w, input logic [7:0] sel, input logic [7:0] v);
		ahb(1'b1, HREG_ADDR, {24'h0, sel});
		ahb(1'b1, HREG_WDATA, {24'h0, v});
		ahb(1'b1, HREG_CMD, {31'h0, w});
		wait_idle();
		ahb(1'b0, HREG_RDATA, 32'h0);
	endtask
	task automatic hard_reset();
		ahb(1'b1, HREG_RESET, 32'h1);
		repeat (10) @(posedge mclk);
		chk(rts_n, 2'h3);
		chk(power_down, 2'h0);
		wait_idle();
		repeat (8) @(posedge mclk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_rts();
		dev_acc(1'b1, ADDR_MODE_A, 8'h01);
		repeat (4) @(posedge mclk);
		chk(rts_n[0], 1'b0);
		tx_busy <= 2'h1;
		dev_acc(1'b1, ADDR_MODE_A, 8'h00);
		repeat (4) @(posedge mclk);
		chk(rts_n[0], 1'b0);
		tx_busy <= 2'h0;
		repeat (4) @(posedge mclk);
		chk(rts_n[0], 1'b1);
	endtask
	task automatic t_cts();
		cts <= 2'h2;
		repeat (4) @(posedge mclk);
		chk(tx_en, 2'h1);
		cts <= 2'h1;
		repeat (4) @(posedge mclk);
		chk(tx_en, 2'h2);
	endtask
	task automatic t_txd();
		tx_bit <= 2'h3;
		dev_acc(1'b1, ADDR_MODE_A, 8'h00);
		chk({txd_oe_n[0], txd_o[0]}, 2'h1);
		dev_acc(1'b1, ADDR_MODE_A, 8'h04);
		chk(txd_oe_n[0], 1'b1);
		tx_bit <= 2'h0;
		@(posedge mclk);
		#1 chk({txd_oe_n[0], txd_o[0]}, 2'h0);
	endtask
	task automatic t_clk();
		dev_acc(1'b1, ADDR_MODE_B, 8'h08);
		dev_acc(1'b0, ADDR_MODE_B, 8'h00);
		chk(r[7:0], 8'h08);
		chk(txclk_oe_n[1], 1'b0);
		time_slot <= 2'h2;
		dev_acc(1'b1, ADDR_CLKM_B, 8'h05);
		chk(txclk_o[1], 1'b1);
		dev_acc(1'b1, ADDR_CLKM_A, 8'h05);
		txclk_in <= 2'h3;
		repeat (4) @(posedge mclk);
		chk(frame_sync, 1'b1);
		chk(rx_strobe, 2'h2);
		txclk_in <= 2'h0;
		repeat (4) @(posedge mclk);
		chk(frame_sync, 1'b0);
		dev_acc(1'b1, ADDR_CLKM_A, 8'h07);
		chk(xtal_en[0], 1'b1);
	endtask
	task automatic t_irq();
		irq_pend <= 2'h1;
		repeat (4) @(posedge mclk);
		ahb(1'b0, HREG_STATUS, 32'h0);
		chk(r[1], 1'b1);
		chk(bus.int_n, 1'b0);
		irq_pend <= 2'h0;
		repeat (4) @(posedge mclk);
		chk(bus.int_n, 1'b1);
		ahb(1'b0, 8'h18, 32'h0);
		chk(hresp, 1'b0);
	endtask
	task automatic t_bus();
		dev_acc(1'b1, ADDR_MODE_B, 8'h02);
		tx_busy <= 2'h2;
		@(posedge mclk);
		#1 chk(rts_n[1], 1'b1);
		repeat (3) @(posedge mclk);
		chk(rts_n[1], 1'b0);
		coll_bit <= 2'h2;
		repeat (4) @(posedge mclk);
		chk(rts_n[1], 1'b1);
		coll_bit <= 2'h0;
		tx_busy <= 2'h0;
		repeat (4) @(posedge mclk);
		chk(rts_n[1], 1'b1);
	endtask
	task automatic t_rst();
		dev_acc(1'b1, ADDR_MODE_A, 8'h01);
		hard_reset();
		chk(power_down, 2'h3);
		chk(rts_n, 2'h3);
	endtask
	// ==========================================
	// clock, main sequence, watchdog
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		hard_reset();
		t_rts();
		t_cts();
		t_txd();
		t_clk();
		t_irq();
		t_bus();
		t_rst();
		conclude();
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		n_fail++;
		conclude();
	end
endmodule
